// *** rtl/alu_ops_pkg.sv ***
// constants and types shared by the subtract / xor / swap datapath
package alu_ops_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 7;
    localparam int unsigned NIBBLE_W    = 4;
    localparam int unsigned LO_NIB_LSB  = 0;
    localparam int unsigned HI_NIB_LSB  = 4;
    localparam int unsigned DC_BIT      = 4;

    localparam logic [DATA_W-1:0] WORK_RESET    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET    = 7'h00;
    localparam logic              FLAG_RESET    = 1'b0;
    localparam logic              DEST_WORK     = 1'b0;
    localparam logic              DEST_FILE     = 1'b1;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

    // one result per accepted instruction, available one clock after the request
    localparam int unsigned RESULT_LATENCY = 1;

    typedef enum logic [2:0] {
        LITERAL_MINUS_WORK,
        XOR_LITERAL_INTO_WORK,
        FILE_MINUS_WORK,
        XOR_WORK_WITH_FILE,
        NIBBLE_EXCHANGE_FILE
    } op_t;

endpackage

// *** rtl/alu_link_if.sv ***
// operand and result bundle between the datapath control and its arithmetic unit
`timescale 1ns/1ps
interface alu_link_if;
    import alu_ops_pkg::*;

    op_t               op;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] work;
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              digit_carry;
    logic              zero;
    logic              update_carries;
    logic              update_zero;
    logic              known_op;

    modport requester (
        output op,
        output src,
        output work,
        input  result,
        input  carry,
        input  digit_carry,
        input  zero,
        input  update_carries,
        input  update_zero,
        input  known_op
    );

    modport calc (
        input  op,
        input  src,
        input  work,
        output result,
        output carry,
        output digit_carry,
        output zero,
        output update_carries,
        output update_zero,
        output known_op
    );
endinterface

// *** rtl/sub_xor_swap_calc.sv ***
// combinational arithmetic for subtract, exclusive-or and nibble exchange
`timescale 1ns/1ps
module sub_xor_swap_calc
    import alu_ops_pkg::*;
(
    alu_link_if.calc link
);

    logic [DATA_W:0]   diff;
    logic [NIBBLE_W:0] nib_diff;

    always_comb begin
        // src + ~work + 1: the carry out is set exactly when no borrow occurs
        diff     = {1'b0, link.src} + {1'b0, ~link.work} + 9'h001;
        nib_diff = {1'b0, link.src[NIBBLE_W-1:0]} + {1'b0, ~link.work[NIBBLE_W-1:0]} + 5'h01;
        link.result         = ZERO_BYTE;
        link.carry          = 1'b0;
        link.digit_carry    = 1'b0;
        link.update_carries = 1'b0;
        link.update_zero    = 1'b0;
        link.known_op       = 1'b1;
        case (link.op)
            LITERAL_MINUS_WORK, FILE_MINUS_WORK: begin
                link.result         = diff[DATA_W-1:0];
                link.carry          = diff[DATA_W];
                link.digit_carry    = nib_diff[NIBBLE_W];
                link.update_carries = 1'b1;
                link.update_zero    = 1'b1;
            end
            XOR_LITERAL_INTO_WORK, XOR_WORK_WITH_FILE: begin
                link.result      = link.src ^ link.work;
                link.update_zero = 1'b1;
            end
            NIBBLE_EXCHANGE_FILE: begin
                link.result = {link.src[LO_NIB_LSB +: NIBBLE_W],
                               link.src[HI_NIB_LSB +: NIBBLE_W]};
            end
            default: begin
                link.known_op = 1'b0;
            end
        endcase
        link.zero = (link.result == ZERO_BYTE);
    end

endmodule // sub_xor_swap_calc

// *** rtl/subtract_xor_swap_alu.sv ***
// execution datapath for literal/file subtract, exclusive-or and nibble exchange
`timescale 1ns/1ps
module subtract_xor_swap_alu
    import alu_ops_pkg::*;
(
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    // instruction request from the decoder
    input  wire logic              op_valid_in,
    input  wire op_t               op_code_in,
    input  wire logic [DATA_W-1:0] literal_in,
    input  wire logic [ADDR_W-1:0] file_addr_in,
    input  wire logic              dest_in,
    // addressed file register contents, read in the same cycle
    input  wire logic [DATA_W-1:0] file_data_in,
    // architectural state
    output logic [DATA_W-1:0]      work_reg_out,
    output logic                   carry_flag_out,
    output logic                   digit_carry_flag_out,
    output logic                   zero_flag_out,
    // file register write-back
    output logic                   file_write_out,
    output logic [ADDR_W-1:0]      file_write_addr_out,
    output logic [DATA_W-1:0]      file_write_data_out,
    // completion
    output logic                   done_out
);

    typedef struct packed {
        logic [DATA_W-1:0] work;
        logic              carry;
        logic              digit_carry;
        logic              zero;
        logic              wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic              done;
    } state_t;

    localparam state_t STATE_RESET = '{
        work:        WORK_RESET,
        carry:       FLAG_RESET,
        digit_carry: FLAG_RESET,
        zero:        FLAG_RESET,
        wr_en:       1'b0,
        wr_addr:     ADDR_RESET,
        wr_data:     ZERO_BYTE,
        done:        1'b0
    };

    state_t state_reg;
    state_t state_next;

    alu_link_if link ();

    function automatic logic is_file_op(input op_t op);
        is_file_op = (op == FILE_MINUS_WORK) || (op == XOR_WORK_WITH_FILE) ||
                     (op == NIBBLE_EXCHANGE_FILE);
    endfunction

    function automatic logic is_sub_op(input op_t op);
        is_sub_op = (op == LITERAL_MINUS_WORK) || (op == FILE_MINUS_WORK);
    endfunction

    sub_xor_swap_calc u_calc (
        .link (link.calc)
    );

    // literal ops take the immediate, file ops the addressed register
    assign link.op   = op_code_in;
    assign link.src  = is_file_op(op_code_in) ? file_data_in : literal_in;
    assign link.work = state_reg.work;

    always_comb begin
        state_next         = state_reg;
        state_next.wr_en   = 1'b0;
        state_next.done    = 1'b0;
        // unknown codes are dropped silently so a decoder glitch cannot corrupt state
        if (op_valid_in && link.known_op) begin
            state_next.done = 1'b1;
            if (is_file_op(op_code_in) && (dest_in == DEST_FILE)) begin
                state_next.wr_en   = 1'b1;
                state_next.wr_addr = file_addr_in;
                state_next.wr_data = link.result;
            end else begin
                state_next.work = link.result;
            end
            if (link.update_carries) begin
                state_next.carry       = link.carry;
                state_next.digit_carry = link.digit_carry;
            end
            if (link.update_zero) begin
                state_next.zero = link.zero;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign work_reg_out         = state_reg.work;
    assign carry_flag_out       = state_reg.carry;
    assign digit_carry_flag_out = state_reg.digit_carry;
    assign zero_flag_out        = state_reg.zero;
    assign file_write_out       = state_reg.wr_en;
    assign file_write_addr_out  = state_reg.wr_addr;
    assign file_write_data_out  = state_reg.wr_data;
    assign done_out             = state_reg.done;

    // checks on the registered outputs, one clock after each request (one and two for AST_DEST_WORK), accepted or refused, or idle cycle

    AST_LITERAL_SUB: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == LITERAL_MINUS_WORK)
        |=> (work_reg_out == 8'($past(literal_in) - $past(work_reg_out)))
            && !file_write_out && done_out)
        else $error("literal subtract result wrong");

    AST_LITERAL_XOR: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == XOR_LITERAL_INTO_WORK)
        |=> (work_reg_out == ($past(literal_in) ^ $past(work_reg_out)))
            && $stable(carry_flag_out) && $stable(digit_carry_flag_out))
        else $error("literal xor result or flags wrong");

    AST_FILE_SUB_BACK: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == FILE_MINUS_WORK && dest_in == DEST_FILE)
        |=> file_write_out
            && (file_write_data_out == 8'($past(file_data_in) - $past(work_reg_out)))
            && (file_write_addr_out == $past(file_addr_in)))
        else $error("file subtract write-back wrong");

    AST_DEST_WORK: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && is_file_op(op_code_in) && dest_in == DEST_WORK)
        |=> !file_write_out ##1 !file_write_out || $past(op_valid_in))
        else $error("file write raised for work destination");

    AST_DEST_FILE: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && is_file_op(op_code_in) && dest_in == DEST_FILE)
        |=> file_write_out && $stable(work_reg_out))
        else $error("work register changed on file destination");

    AST_FILE_XOR_FLAGS: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == XOR_WORK_WITH_FILE && dest_in == DEST_WORK)
        |=> (work_reg_out == ($past(file_data_in) ^ $past(work_reg_out)))
            && (zero_flag_out == (work_reg_out == ZERO_BYTE))
            && $stable(carry_flag_out))
        else $error("file xor result or flags wrong");

    AST_SWAP: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == NIBBLE_EXCHANGE_FILE && dest_in == DEST_FILE)
        |=> (file_write_data_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])})
            && $stable(zero_flag_out) && $stable(carry_flag_out)
            && $stable(digit_carry_flag_out))
        else $error("nibble exchange wrong or flags touched");

    AST_SUB_CARRIES: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && is_sub_op(op_code_in))
        |=> (carry_flag_out == ($past(link.src) >= $past(work_reg_out)))
            && (digit_carry_flag_out ==
                ($past(link.src[3:0]) >= $past(work_reg_out[3:0]))))
        else $error("subtract borrow flags wrong");

    AST_IDLE_QUIET: assert property (@(posedge clock_in) disable iff (rst_in)
        !op_valid_in |=> !done_out && !file_write_out && $stable(work_reg_out))
        else $error("state changed without a request");

    AST_FILE_SUB_WORK: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == FILE_MINUS_WORK && dest_in == DEST_WORK)
        |=> (work_reg_out == 8'($past(file_data_in) - $past(work_reg_out)))
            && !file_write_out && done_out)
        else $error("file subtract to work wrong");

    AST_FILE_XOR_BACK: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == XOR_WORK_WITH_FILE && dest_in == DEST_FILE)
        |=> file_write_out
            && (file_write_data_out == ($past(file_data_in) ^ $past(work_reg_out)))
            && $stable(carry_flag_out) && $stable(digit_carry_flag_out))
        else $error("file xor write-back or flags wrong");

    AST_SWAP_WORK: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in == NIBBLE_EXCHANGE_FILE && dest_in == DEST_WORK)
        |=> (work_reg_out == {$past(file_data_in[LO_NIB_LSB +: NIBBLE_W]),
                              $past(file_data_in[HI_NIB_LSB +: NIBBLE_W])})
            && !file_write_out && $stable(zero_flag_out) && $stable(carry_flag_out)
            && $stable(digit_carry_flag_out))
        else $error("nibble exchange to work wrong or flags touched");

    // literal ops have no file operand, so a stray destination bit must not write back
    AST_LIT_NO_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && !is_file_op(op_code_in))
        |=> !file_write_out)
        else $error("file write raised by a literal op");

    // a difference and an xor are both zero exactly when the two operands are equal
    AST_ZERO_FLAG: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && (is_sub_op(op_code_in) || op_code_in == XOR_LITERAL_INTO_WORK
                         || op_code_in == XOR_WORK_WITH_FILE))
        |=> (zero_flag_out == ($past(link.src) == $past(work_reg_out))))
        else $error("zero flag wrong");

    AST_REFUSED_CODE: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in > NIBBLE_EXCHANGE_FILE)
        |=> !done_out && !file_write_out && $stable(work_reg_out)
            && $stable(zero_flag_out) && $stable(carry_flag_out)
            && $stable(digit_carry_flag_out))
        else $error("unknown code changed state");

    AST_DONE_PULSE: assert property (@(posedge clock_in) disable iff (rst_in)
        (op_valid_in && op_code_in <= NIBBLE_EXCHANGE_FILE)
        |=> done_out)
        else $error("accepted op gave no completion pulse");

endmodule // subtract_xor_swap_alu

// *** sim/file_array_model.sv ***
// behavioural file register array that faces the datapath
`timescale 1ns/1ps
module file_array_model
    import alu_ops_pkg::*;
(
    // clock
    input  wire logic              clock_in,
    // read port, combinational
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0]      rd_data_out,
    // write-back port from the datapath
    input  wire logic              wr_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in
);
    logic [DATA_W-1:0] mem [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = DATA_W'(i * 37 + 5);
        end
    end
    // write-back lands one edge late, so forward it or a back-to-back op reads stale data
    assign rd_data_out = (wr_in && wr_addr_in == rd_addr_in) ? wr_data_in : mem[rd_addr_in];
    always @(posedge clock_in) begin
        if (wr_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end
endmodule // file_array_model

// *** sim/subtract_xor_swap_alu_bench.sv ***
// self-checking bench for the subtract / xor / swap datapath
`timescale 1ns/1ps
module subtract_xor_swap_alu_bench;
    import alu_ops_pkg::*;
    logic              clock_in;
    logic              rst_in;
    logic              op_valid_in;
    op_t               op_code_in;
    logic [DATA_W-1:0] literal_in;
    logic [ADDR_W-1:0] file_addr_in;
    logic              dest_in;
    logic [DATA_W-1:0] file_data_in;
    logic [DATA_W-1:0] work_reg_out;
    logic              carry_flag_out;
    logic              digit_carry_flag_out;
    logic              zero_flag_out;
    logic              file_write_out;
    logic [ADDR_W-1:0] file_write_addr_out;
    logic [DATA_W-1:0] file_write_data_out;
    logic              done_out;
    int                errors;
    int                cmp_count;
    logic [15:0]       lfsr;
    logic [DATA_W-1:0] mem_copy [128];
    logic [DATA_W-1:0] ew;
    logic              ec;
    logic              edc;
    logic              ez;
    logic              ewr;
    logic              edone;
    logic [ADDR_W-1:0] ewa;
    logic [DATA_W-1:0] ewd;

    subtract_xor_swap_alu dut (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .literal_in(literal_in), .file_addr_in(file_addr_in),
        .dest_in(dest_in), .file_data_in(file_data_in), .work_reg_out(work_reg_out),
        .carry_flag_out(carry_flag_out), .digit_carry_flag_out(digit_carry_flag_out),
        .zero_flag_out(zero_flag_out), .file_write_out(file_write_out),
        .file_write_addr_out(file_write_addr_out), .file_write_data_out(file_write_data_out),
        .done_out(done_out));
    file_array_model files (.clock_in(clock_in), .rd_addr_in(file_addr_in),
        .rd_data_out(file_data_in), .wr_in(file_write_out), .wr_addr_in(file_write_addr_out),
        .wr_data_in(file_write_data_out));

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // eight shifts per draw so consecutive draws are less correlated
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        for (int i = 0; i < 8; i++) begin
            x = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
        end
        return x;
    endfunction

    task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            errors++;
        end
    endtask

    task automatic model(input logic v, input op_t o, input logic [7:0] k, input logic [6:0] a,
                         input logic d);
        logic [DATA_W-1:0] s;
        logic [DATA_W-1:0] r;
        s = (o == LITERAL_MINUS_WORK || o == XOR_LITERAL_INTO_WORK) ? k : mem_copy[a];
        ewr = 1'b0;
        edone = 1'b0;
        if (v && o <= NIBBLE_EXCHANGE_FILE) begin
            edone = 1'b1;
            case (o)
                LITERAL_MINUS_WORK, FILE_MINUS_WORK: begin
                    r = s - ew;
                    ec = s >= ew;
                    edc = s[3:0] >= ew[3:0];
                    ez = r == ZERO_BYTE;
                end
                XOR_LITERAL_INTO_WORK, XOR_WORK_WITH_FILE: begin
                    r = s ^ ew;
                    ez = r == ZERO_BYTE;
                end
                default: r = {s[3:0], s[7:4]};
            endcase
            if (o >= FILE_MINUS_WORK && d) begin
                ewr = 1'b1;
                ewa = a;
                ewd = r;
                mem_copy[a] = r;
            end else begin
                ew = r;
            end
        end
    endtask

    task automatic drive(input logic v, input op_t o, input logic [7:0] k, input logic [6:0] a,
                         input logic d);
        @(posedge clock_in);
        op_valid_in <= v;
        op_code_in <= o;
        literal_in <= k;
        file_addr_in <= a;
        dest_in <= d;
        @(negedge clock_in);
        check("work", work_reg_out, ew);
        check("flags", {4'h0, carry_flag_out, digit_carry_flag_out, zero_flag_out, done_out},
              {4'h0, ec, edc, ez, edone});
        check("write", {file_write_out, file_write_addr_out}, {ewr, ewa});
        check("write data", file_write_data_out, ewd);
        model(v, o, k, a, d);
    endtask

    task automatic do_reset();
        @(posedge clock_in);
        rst_in <= 1'b1;
        op_valid_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        {ew, ec, edc, ez, ewr, edone, ewa, ewd} = '0;
    endtask

    task automatic random_run(input int n);
        logic [15:0] b;
        for (int i = 0; i < n; i++) begin
            lfsr = lfsr_next(lfsr);
            b = lfsr_next(lfsr);
            drive(lfsr[3:0] != 4'h0, op_t'(lfsr[6:4]), lfsr[15:8], b[15] ? {4'h0, b[2:0]} : b[14:8],
                  b[7]);
            lfsr = b;
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {rst_in, op_valid_in, dest_in, literal_in, file_addr_in} = '0;
        op_code_in = LITERAL_MINUS_WORK;
        errors = 0;
        cmp_count = 0;
        lfsr = 16'h004d;
        for (int i = 0; i < 128; i++) begin
            mem_copy[i] = DATA_W'(i * 37 + 5);
        end
        do_reset();
        $display("test reset done");
        // equal operands give zero with no borrow, then zero minus one borrows from both halves
        drive(1'b1, XOR_LITERAL_INTO_WORK, 8'h5a, 7'h00, 1'b1);
        drive(1'b1, LITERAL_MINUS_WORK, 8'h5a, 7'h7f, 1'b1);
        drive(1'b1, XOR_LITERAL_INTO_WORK, 8'h01, 7'h00, 1'b0);
        drive(1'b1, LITERAL_MINUS_WORK, 8'h00, 7'h00, 1'b0);
        drive(1'b1, FILE_MINUS_WORK, 8'h00, 7'h7f, 1'b1);
        drive(1'b1, FILE_MINUS_WORK, 8'h00, 7'h7f, 1'b0);
        drive(1'b1, NIBBLE_EXCHANGE_FILE, 8'h00, 7'h7f, 1'b1);
        drive(1'b1, op_t'(3'h7), 8'h00, 7'h7f, 1'b1);
        drive(1'b0, XOR_WORK_WITH_FILE, 8'h00, 7'h7f, 1'b1);
        $display("test corner done");
        random_run(600);
        $display("test random done");
        do_reset();
        random_run(200);
        // one idle slot so the last random op is compared as well
        drive(1'b0, LITERAL_MINUS_WORK, 8'h00, 7'h00, 1'b0);
        $display("test second reset done");
        give_verdict();
    end
endmodule // subtract_xor_swap_alu_bench
